/* rtl/pgc_regs.vh */
// Purpose: offsets, field positions, reset values and gate timing for the gate control block
// Assumes: byte-wide management map, 50 MHz system clock
// Notes:   gate times in seconds; cycle counts derived from the clock rate
`ifndef PGC_REGS_VH
`define PGC_REGS_VH
`define PGC_OFS_CLK_SEL      8'hB0
`define PGC_OFS_GATE_CTL     8'hB1
`define PGC_RST_CLK_SEL      8'h00
`define PGC_RST_GATE_CTL     8'h00
`define PGC_GEN_HOST_HI      7
`define PGC_GEN_HOST_LO      4
`define PGC_GEN_MEDIA_HI     3
`define PGC_GEN_MEDIA_LO     0
`define PGC_BIT_ALL_LANES    7
`define PGC_BIT_RSVD         6
`define PGC_BIT_ERR_RESET    5
`define PGC_BIT_AUTO_RESTART 4
`define PGC_GATE_HI          3
`define PGC_GATE_LO          1
`define PGC_BIT_UPD_RATE     0
`define PGC_CSRC_INTERNAL    4'h0
`define PGC_CSRC_REFERENCE   4'h1
`define PGC_CSRC_LANE_FIRST  4'h2
`define PGC_CSRC_LANE_LAST   4'h9
`define PGC_CSRC_OWN_LANE    4'hF
`define PGC_GATE_NONE        3'h0
`define PGC_GATE_CUSTOM      3'h7
`define PGC_CLK_HZ           50000000
`define PGC_GATE_S1          5
`define PGC_GATE_S2          10
`define PGC_GATE_S3          30
`define PGC_GATE_S4          60
`define PGC_GATE_S5          120
`define PGC_GATE_S6          300
`define PGC_TICK_CYC         `PGC_CLK_HZ
`endif

/* rtl/pgc_lane_timer.v */
// Purpose: one gate timer counting whole seconds against a target
// Assumes: tick_i is a one-cycle pulse once per second
// Notes:   expiry is a one-cycle pulse; restart reloads in that same cycle
`timescale 1ns/100ps
module pgc_lane_timer (
	input  wire        clk_sys_i,   // system clock
	input  wire        rst_i,       // synchronous reset, active high
	input  wire        hold_i,      // keep timer cleared
	input  wire        run_i,       // lane enabled for timing
	input  wire        tick_i,      // one-second enable
	input  wire [8:0]  target_i,    // gate length in seconds, zero = ungated
	input  wire        restart_i,   // reload on expiry
	output reg         expire_o,    // gate expiry pulse
	output reg         done_o       // gate finished, counting stopped
);
	reg [8:0] secs;

	always @(posedge clk_sys_i) begin
		expire_o <= 1'b0;
		if (rst_i || hold_i) begin
			secs   <= 9'h000;
			done_o <= 1'b0;
		end else if (run_i && !done_o && tick_i && target_i != 9'h000) begin
			if (secs + 9'h001 >= target_i) begin
				expire_o <= 1'b1;
				secs     <= 9'h000;
				done_o   <= ~restart_i;
			end else begin
				secs <= secs + 9'h001;
			end
		end
	end
endmodule // pgc_lane_timer

/* rtl/pgc_gate_ctrl.v */
// Purpose: generator clock selection and checker gate/error-information control
// Assumes: byte register port from the management interface; 8 checker lanes per bank
// Notes:   error counters live outside; this block issues clear/freeze/latch commands
//
// Overview of operation
// - host generator clock source from upper nibble
// - media generator clock source from lower nibble
// - scope bit: this bank or all banks
// - error reset clears ratio and counters together
// - reset bit high freezes, snapshots live info
// - reset bit low zeroes live, keeps snapshot
// - single shared timer when per-lane absent
// - per-lane timers held only in this-bank scope, started per bank
// - expiry without restart latches then stops
// - expiry with restart latches, clears, continues
// - every expiry sets gate complete flag
// - gate code selects ungated, fixed or custom
// - ungated mode raises no complete flag
`timescale 1ns/100ps
`include "pgc_regs.vh"
module pgc_gate_ctrl #(
	// clocks per gate second; a bench may shrink it so gates can expire in a short run
	parameter [25:0] TICK_CYC = 26'd`PGC_TICK_CYC
) (
	input  wire        clk_sys_i,       // system clock
	input  wire        rst_i,           // synchronous reset, active high
	input  wire [7:0]  reg_addr_i,      // register byte address
	input  wire [7:0]  reg_wdata_i,     // write data
	input  wire        reg_wr_i,        // write strobe
	output reg  [7:0]  reg_rdata_o,     // read data
	input  wire        per_lane_cap_i,  // per-lane timer capability
	input  wire [7:0]  lane_en_i,       // checker lane enables
	input  wire [8:0]  custom_secs_i,   // custom gate length, seconds
	output reg  [3:0]  host_gen_src_o,  // host generator clock source code
	output reg  [3:0]  media_gen_src_o, // media generator clock source code
	output reg  [7:0]  host_gen_sel_o,  // per-lane host generator clock select
	output reg  [7:0]  media_gen_sel_o, // per-lane media generator clock select
	output reg  [1:0]  host_gen_kind_o, // 0 internal 1 reference 2 recovered 3 invalid
	output reg  [1:0]  media_gen_kind_o,// same for media generators
	output reg         all_banks_o,     // scope of lane operations
	output reg  [7:0]  err_clear_o,     // clear ratio and counters per lane
	output reg  [7:0]  err_freeze_o,    // live error info frozen per lane
	output reg  [7:0]  snap_load_o,     // copy live info to snapshot, pulse
	output reg  [7:0]  latch_upd_o,     // update latched counters, pulse
	output reg  [7:0]  count_en_o,      // error detection active per lane
	output reg  [7:0]  gate_done_o,     // gate complete flag set pulse
	output reg         update_rate_o    // update interval select
);
	reg  [7:0] clk_sel;
	reg  [7:0] gate_ctl;
	reg  [8:0] gate_secs;
	reg  [25:0] sec_cnt;
	reg        tick;
	reg        rst_bit_q;
	wire       err_reset = gate_ctl[`PGC_BIT_ERR_RESET];
	wire       restart   = gate_ctl[`PGC_BIT_AUTO_RESTART];
	wire [2:0] gate_code = gate_ctl[`PGC_GATE_HI:`PGC_GATE_LO];
	wire       start_pul = rst_bit_q & ~err_reset;
	wire [7:0] expire;
	wire [7:0] done;
	wire       sh_expire;
	wire       sh_done;

	// register writes
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			clk_sel  <= `PGC_RST_CLK_SEL;
			gate_ctl <= `PGC_RST_GATE_CTL;
		end else if (reg_wr_i) begin
			if (reg_addr_i == `PGC_OFS_CLK_SEL) begin
				clk_sel <= reg_wdata_i;
			end else if (reg_addr_i == `PGC_OFS_GATE_CTL) begin
				gate_ctl <= reg_wdata_i;
				gate_ctl[`PGC_BIT_RSVD] <= 1'b0;
			end
		end
	end

	// register reads; unmapped bytes read zero
	always @* begin
		if (reg_addr_i == `PGC_OFS_CLK_SEL) begin
			reg_rdata_o = clk_sel;
		end else if (reg_addr_i == `PGC_OFS_GATE_CTL) begin
			reg_rdata_o = gate_ctl;
		end else begin
			reg_rdata_o = 8'h00;
		end
	end

	// decode a generator clock code into kind and lane mask
	function [9:0] src_decode;
		input [3:0] code;
		begin
			if (code == `PGC_CSRC_INTERNAL) begin
				src_decode = {2'd0, 8'h00};
			end else if (code == `PGC_CSRC_REFERENCE) begin
				src_decode = {2'd1, 8'h00};
			end else if (code >= `PGC_CSRC_LANE_FIRST && code <= `PGC_CSRC_LANE_LAST) begin
				src_decode = {2'd2, 8'h01 << (code - `PGC_CSRC_LANE_FIRST)};
			end else if (code == `PGC_CSRC_OWN_LANE) begin
				src_decode = {2'd2, 8'hFF};
			end else begin
				src_decode = {2'd3, 8'h00};
			end
		end
	endfunction

	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			host_gen_src_o   <= 4'h0;
			media_gen_src_o  <= 4'h0;
			host_gen_kind_o  <= 2'h0;
			media_gen_kind_o <= 2'h0;
			host_gen_sel_o   <= 8'h00;
			media_gen_sel_o  <= 8'h00;
			all_banks_o      <= 1'b0;
			update_rate_o    <= 1'b0;
		end else begin
			host_gen_src_o <= clk_sel[`PGC_GEN_HOST_HI:`PGC_GEN_HOST_LO];
			{host_gen_kind_o, host_gen_sel_o} <=
				src_decode(clk_sel[`PGC_GEN_HOST_HI:`PGC_GEN_HOST_LO]);
			media_gen_src_o <= clk_sel[`PGC_GEN_MEDIA_HI:`PGC_GEN_MEDIA_LO];
			{media_gen_kind_o, media_gen_sel_o} <=
				src_decode(clk_sel[`PGC_GEN_MEDIA_HI:`PGC_GEN_MEDIA_LO]);
			all_banks_o   <= gate_ctl[`PGC_BIT_ALL_LANES];
			update_rate_o <= gate_ctl[`PGC_BIT_UPD_RATE];
		end
	end

	always @* begin
		case (gate_code)
			3'h1:    gate_secs = 9'd`PGC_GATE_S1;
			3'h2:    gate_secs = 9'd`PGC_GATE_S2;
			3'h3:    gate_secs = 9'd`PGC_GATE_S3;
			3'h4:    gate_secs = 9'd`PGC_GATE_S4;
			3'h5:    gate_secs = 9'd`PGC_GATE_S5;
			3'h6:    gate_secs = 9'd`PGC_GATE_S6;
			3'h7:    gate_secs = custom_secs_i;
			default: gate_secs = 9'h000;
		endcase
	end

	// one-second enable; restarted with the timers so gates are whole seconds
	always @(posedge clk_sys_i) begin
		tick <= 1'b0;
		if (rst_i || err_reset) begin
			sec_cnt <= 26'h0;
		end else if (sec_cnt == TICK_CYC - 26'd1) begin
			sec_cnt <= 26'h0;
			tick    <= 1'b1;
		end else begin
			sec_cnt <= sec_cnt + 26'h1;
		end
	end

	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			rst_bit_q <= 1'b0;
		end else begin
			rst_bit_q <= err_reset;
		end
	end

	// shared timer, held by the reset bit
	pgc_lane_timer u_shared (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.hold_i    (err_reset),
		.run_i     (|lane_en_i),
		.tick_i    (tick),
		.target_i  (gate_secs),
		.restart_i (restart),
		.expire_o  (sh_expire),
		.done_o    (sh_done)
	);

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_lane
			// per-lane timer for enabled lanes of this bank
			pgc_lane_timer u_tmr (
				.clk_sys_i (clk_sys_i),
				.rst_i     (rst_i),
				.hold_i    (err_reset & ~gate_ctl[`PGC_BIT_ALL_LANES]),
				.run_i     (lane_en_i[gi]),
				.tick_i    (tick),
				.target_i  (gate_secs),
				.restart_i (restart),
				.expire_o  (expire[gi]),
				.done_o    (done[gi])
			);

			always @(posedge clk_sys_i) begin
				if (rst_i) begin
					err_clear_o[gi]  <= 1'b0;
					err_freeze_o[gi] <= 1'b0;
					snap_load_o[gi]  <= 1'b0;
					latch_upd_o[gi]  <= 1'b0;
					count_en_o[gi]   <= 1'b0;
					gate_done_o[gi]  <= 1'b0;
				end else begin
					// freeze while bit high, snapshot on rise
					err_freeze_o[gi] <= err_reset & lane_en_i[gi];
					snap_load_o[gi]  <= err_reset & ~rst_bit_q & lane_en_i[gi];
					// ratio and counters cleared in one pulse
					// zero live info on release; snapshot untouched
					err_clear_o[gi] <= lane_en_i[gi] & (start_pul |
						(restart & (per_lane_cap_i ? expire[gi] : sh_expire)));
					// latch on expiry, stop counting after unless restart is set
					latch_upd_o[gi] <= lane_en_i[gi] &
						(per_lane_cap_i ? expire[gi] : sh_expire);
					count_en_o[gi] <= lane_en_i[gi] & ~err_reset &
						~(per_lane_cap_i ? done[gi] : sh_done);
					// ungated timers never expire, so no flag
					gate_done_o[gi] <= lane_en_i[gi] &
						(per_lane_cap_i ? expire[gi] : sh_expire);
				end
			end
		end
	endgenerate
endmodule // pgc_gate_ctrl

/* sim/pgc_gate_ctrl_assertions.sv */
// Purpose: port-level checks for the gate control block
// Assumes: one clock domain, synchronous reset
// Notes:   gate byte is shadowed from writes to judge modes
`timescale 1ns/100ps
module pgc_gate_ctrl_assertions (
	input wire       clk_sys_i,      // clock
	input wire       rst_i,          // reset
	input wire [7:0] reg_addr_i,     // address
	input wire [7:0] reg_wdata_i,    // wdata
	input wire       reg_wr_i,       // strobe
	input wire [7:0] reg_rdata_o,    // rdata
	input wire [7:0] lane_en_i,      // lanes
	input wire [3:0] host_gen_src_o, // source
	input wire       all_banks_o,    // scope
	input wire [7:0] err_clear_o,    // clear
	input wire [7:0] err_freeze_o,   // freeze
	input wire [7:0] snap_load_o,    // snap
	input wire [7:0] latch_upd_o,    // latch
	input wire [7:0] count_en_o,     // count
	input wire [7:0] gate_done_o     // done
);
	wire       wr_gate = reg_wr_i && reg_addr_i == 8'hB1;
	reg  [7:0] shad;
	reg  [2:0] gate_q;
	always @(posedge clk_sys_i) begin
		shad   <= rst_i ? 8'h00 : wr_gate ? reg_wdata_i : shad;
		gate_q <= shad[3:1];
	end
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	sequence s_set;
		wr_gate && reg_wdata_i[5] && !shad[5];
	endsequence
	sequence s_rel;
		wr_gate && !reg_wdata_i[5] && shad[5];
	endsequence
	a_rsvd_reads_zero: assert property (
		reg_addr_i == 8'hB1 |-> !reg_rdata_o[6]) else $error("reserved bit read high");
	a_host_src_copy: assert property (
		reg_wr_i && reg_addr_i == 8'hB0 |-> ##2 host_gen_src_o == ($past(reg_wdata_i, 2) >> 4))
		else $error("host source not taken");
	a_scope_copy: assert property (
		wr_gate |-> ##2 all_banks_o == ($past(reg_wdata_i, 2) >> 7)) else $error("scope bad");
	a_freeze_then_snap: assert property (
		s_set |-> ##2 (err_freeze_o == $past(lane_en_i) && snap_load_o == $past(lane_en_i))
		##1 snap_load_o == 8'h00) else $error("freeze or snapshot wrong");
	a_release_clears: assert property (
		s_rel |-> ##2 err_clear_o == $past(lane_en_i) && err_freeze_o == 8'h00)
		else $error("release did not clear");
	a_ungated_no_flag: assert property (
		shad[3:1] == 3'h0 && gate_q == 3'h0 && $past(gate_q) == 3'h0 |-> gate_done_o == 8'h00)
		else $error("flag raised while ungated");
	a_flag_on_expiry: assert property (
		latch_upd_o != 8'h00 |-> gate_done_o == latch_upd_o) else $error("flag missing");
	a_stop_no_restart: assert property (
		latch_upd_o != 8'h00 && !shad[4] |=> (count_en_o & $past(latch_upd_o)) == 8'h00)
		else $error("counting went on");
	a_restart_keeps: assert property (
		latch_upd_o != 8'h00 && shad[4] |-> err_clear_o == latch_upd_o
		##1 (count_en_o & $past(latch_upd_o)) == $past(latch_upd_o)) else $error("no restart");
endmodule // pgc_gate_ctrl_assertions
bind pgc_gate_ctrl pgc_gate_ctrl_assertions u_chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
	.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
	.reg_rdata_o(reg_rdata_o), .lane_en_i(lane_en_i), .host_gen_src_o(host_gen_src_o),
	.all_banks_o(all_banks_o), .err_clear_o(err_clear_o), .err_freeze_o(err_freeze_o),
	.snap_load_o(snap_load_o), .latch_upd_o(latch_upd_o), .count_en_o(count_en_o),
	.gate_done_o(gate_done_o));

/* sim/pgc_host_model.sv */
// Purpose: management host issuing byte writes and reads
// Assumes: bus changes only just after a rising edge
// Notes:   write data is scrambled once released
`timescale 1ns/100ps
module pgc_host_model (
	input  wire       clk_sys_i, // clock
	input  wire [7:0] rdata_i,   // read data
	output reg  [7:0] addr_o,    // address
	output reg  [7:0] wdata_o,   // write data
	output reg        wr_o       // strobe
);
	initial begin
		addr_o  = 8'h00;
		wdata_o = 8'h00;
		wr_o    = 1'b0;
	end
	task wr(input [7:0] a, input [7:0] d);
		begin
			@(posedge clk_sys_i);
			addr_o  <= a;
			wdata_o <= d;
			wr_o    <= 1'b1;
			@(posedge clk_sys_i);
			wr_o    <= 1'b0;
			wdata_o <= ~d;
		end
	endtask
	task rd(input [7:0] a, output [7:0] d);
		begin
			@(posedge clk_sys_i);
			addr_o <= a;
			@(posedge clk_sys_i);
			d = rdata_i;
		end
	endtask
endmodule // pgc_host_model

/* sim/prbs_gate_control_tb_top.sv */
// Purpose: directed register tests for the gate control block
// Assumes: host model performs every register cycle
// Notes:   gate second shortened through the dut parameter so gates expire in the run
`timescale 1ns/100ps
module prbs_gate_control_tb_top;
	reg        clk_sys_i = 1'b0;
	reg        rst_i     = 1'b1;
	reg  [7:0] lane_en   = 8'h00;
	reg        cap       = 1'b0;
	localparam [25:0] TICK = 26'd20;
	wire [7:0] addr, wdata, rdata, hsel, msel, clr, frz, snap, lat, cen, done;
	wire [3:0] hsrc, msrc;
	wire [1:0] hknd, mknd;
	wire       wr, banks, rate;
	integer    miscompares = 0;
	integer    num_checks  = 0;
	integer    cyc         = 0;
	integer    i;
	integer    t0;
	reg  [7:0] d;
	reg  [3:0] c;
	always #10 clk_sys_i = ~clk_sys_i;
	pgc_host_model host (.clk_sys_i(clk_sys_i), .rdata_i(rdata), .addr_o(addr),
		.wdata_o(wdata), .wr_o(wr));
	pgc_gate_ctrl #(.TICK_CYC(TICK)) dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rdata_o(rdata),
		.per_lane_cap_i(cap),
		.lane_en_i(lane_en), .custom_secs_i(9'h005), .host_gen_src_o(hsrc),
		.media_gen_src_o(msrc), .host_gen_sel_o(hsel), .media_gen_sel_o(msel),
		.host_gen_kind_o(hknd), .media_gen_kind_o(mknd), .all_banks_o(banks),
		.err_clear_o(clr), .err_freeze_o(frz), .snap_load_o(snap), .latch_upd_o(lat),
		.count_en_o(cen), .gate_done_o(done), .update_rate_o(rate));
	function [1:0] kind(input [3:0] k);
		kind = k == 4'h0 ? 2'h0 : k == 4'h1 ? 2'h1 : (k <= 4'h9 || k == 4'hF) ? 2'h2 : 2'h3;
	endfunction
	function [7:0] sel(input [3:0] k);
		sel = k == 4'hF ? 8'hFF : (k >= 4'h2 && k <= 4'h9) ? 8'h01 << (k - 4'h2) : 8'h00;
	endfunction
	task chk(input [63:0] nm, input [7:0] e, input [7:0] g);
		begin
			num_checks = num_checks + 1;
			if (g !== e) begin
				miscompares = miscompares + 1;
				$display("unexpected %0s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	task step;
		begin
			@(posedge clk_sys_i);
			#1;
		end
	endtask
	task till(input integer t);
		begin
			while (cyc < t)
				step;
		end
	endtask
	task wrap_up;
		begin
			$display("checks %0d miscompares %0d", num_checks, miscompares);
			if (miscompares == 0 && num_checks > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	// a hang past this many cycles counts against the run
	always @(posedge clk_sys_i) begin
		cyc = cyc + 1;
		if (cyc == 3000) begin
			miscompares = miscompares + 1;
			wrap_up;
		end
	end
	initial begin
		repeat (20) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		for (i = 0; i < 3; i = i + 1) begin
			host.rd(8'hB0 + i[7:0], d);
			chk("rstval", 8'h00, d);
		end
		$display("test reset values done");
		for (i = 0; i < 16; i = i + 1) begin
			c = i[3:0];
			host.wr(8'hB0, {c, ~c});
			step;
			chk("host", {c, 2'b00, kind(c)}, {hsrc, 2'b00, hknd});
			chk("hsel", sel(c), hsel);
			chk("media", {~c, 2'b00, kind(~c)}, {msrc, 2'b00, mknd});
			chk("msel", sel(~c), msel);
			host.rd(8'hB0, d);
			chk("clkrd", {c, ~c}, d);
		end
		$display("test clock select done");
		host.wr(8'hB1, 8'hC1);
		host.rd(8'hB1, d);
		chk("gaterd", 8'h81, d);
		chk("scope", 8'h03, {6'h00, banks, rate});
		lane_en <= 8'h5A;
		host.wr(8'hB1, 8'h20);
		step;
		chk("freeze", 8'h5A, frz);
		chk("snap", 8'h5A, snap);
		host.wr(8'hB1, 8'h00);
		step;
		chk("clear", 8'h5A, clr);
		chk("thaw", 8'h00, frz);
		step;
		chk("clrpulse", 8'h00, clr);
		repeat (40) step;
		chk("count", 8'h5A, cen);
		chk("noflag", 8'h00, done);
		$display("test error reset done");
		host.wr(8'hB1, 8'h22);
		host.wr(8'hB1, 8'h02);
		step;
		t0 = cyc;
		till(t0 + 5 * TICK);
		chk("early", 8'h00, lat);
		step;
		chk("latch", 8'h5A, lat);
		chk("flag", 8'h5A, done);
		chk("stop", 8'h00, cen);
		chk("noclr", 8'h00, clr);
		step;
		chk("onepulse", 8'h00, lat);
		$display("test single gate done");
		@(posedge clk_sys_i) cap <= 1'b1;
		host.wr(8'hB1, 8'h32);
		host.wr(8'hB1, 8'h12);
		step;
		t0 = cyc;
		till(t0 + 5 * TICK + 1);
		chk("rlatch", 8'h5A, lat);
		chk("rclear", 8'h5A, clr);
		chk("rflag", 8'h5A, done);
		chk("rcount", 8'h5A, cen);
		host.rd(8'hB1, d);
		chk("rdgate", 8'h12, d);
		till(t0 + 10 * TICK);
		chk("rearly", 8'h00, lat);
		step;
		chk("rlatch2", 8'h5A, lat);
		chk("rcount2", 8'h5A, cen);
		$display("test restart gate done");
		@(posedge clk_sys_i) rst_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		host.rd(8'hB1, d);
		chk("rerst", 8'h00, d);
		host.rd(8'hB0, d);
		chk("rerst0", 8'h00, d);
		$display("test second reset done");
		wrap_up;
	end
endmodule // prbs_gate_control_tb_top
